// [src/sas_defines.vh]
// constants for the scratchpad array sequencer
// assumes inclusion by bare name from the design file
`ifndef SAS_DEFINES_VH
`define SAS_DEFINES_VH
`define SAS_CLK_PER_CYC     4'h8
`define SAS_LAST_PULSE      3'h7
`define SAS_ADDR_HI_END     3'h1
`define SAS_ADDR_LO_END     3'h3
`define SAS_WR_START        3'h4
`define SAS_WR_LEN          2'h2
`define SAS_RD_SAMPLE       3'h5
`define SAS_ST_FETCH        2'h0
`define SAS_ST_EXEC         2'h1
`define SAS_ST_DMA          2'h2
`define SAS_ST_INT          2'h3
`define SAS_I_LOAD          4'h4
`define SAS_I_STORE         4'h5
`define SAS_I_IO            4'h6
`define SAS_I_SEP           4'hD
`define SAS_I_SEX           4'hE
`define SAS_I_ALU           4'hF
`define SAS_I_GLO           4'h8
`define SAS_I_GHI           4'h9
`define SAS_I_INC           4'h1
`define SAS_I_DEC           4'h2
`define SAS_R_DMA           4'h0
`define SAS_R_INTPC         4'h1
`define SAS_R_INTDP         4'h2
`define SAS_RST_SEL         4'h0
`endif

// [src/sas_top.v]
// scratchpad register array and two-cycle instruction sequencer
// assumes synchronous memory returning read data on MEM_RDATA within the
// same eight-pulse cycle; DMA and interrupt requests are asynchronous pins
`timescale 1ns/1ns
`include "sas_defines.vh"

// Contract
// - write strobe is held two machine clock periods.
// - sixteen scratchpad registers of sixteen bits each.
// - register chosen by low nibble, program or data selector.
// - address sent over eight lines, upper byte first then lower.
// - upper or lower byte of chosen register moves to accumulator.
// - chosen register incremented or decremented and written back.
// - address, accumulator and step paths may act together in one cycle.
// - each instruction is a fetch then an execute, eight pulses each.
// - fetch addresses memory through the program counter register.
// - fetched byte splits into high and low opcode nibbles.
// - every fetch increments the program counter register.
// - opcodes F0 to F7 address operand through data pointer register.
// - I/O opcodes 60 to 6F address memory through data pointer.
// - opcodes 4N and 5N use the low-nibble register as pointer.
// - opcodes F8 to FF take operand through the program counter.
// - low nibble shown to peripherals during I/O instructions.
// - set-program and set-data opcodes copy low nibble into selector.
// - register one is program counter while servicing an interrupt.
// - DMA request steals one cycle after the current execute cycle.
// - stolen cycle addresses via register zero; in writes, out reads.
// - register zero increments after every DMA byte.
// - program load mode fills memory through DMA-in requests.
// - interrupt saves selectors, sets them to 1 and 2, clears gate.
// - DMA request wins over a concurrent interrupt request.
module sas_top #(
    parameter NREG = 16
) (
    MCLK,
    RST_N,
    MEM_ADDR,
    MEM_ADDR_HI,
    MEM_READ,
    MEM_WRITE_STROBE,
    MEM_WDATA,
    MEM_WVALID,
    MEM_WREADY,
    MEM_RDATA,
    IO_CMD,
    IO_CMD_VALID,
    DMA_IN_REQ,
    DMA_OUT_REQ,
    INT_REQ,
    PROG_LOAD,
    DMA_DATA_IN,
    ACC_OUT,
    INTERRUPT_GATE,
    SAVED_CTX,
    PC_SEL,
    DP_SEL,
    CYCLE_STATE
);
    input              MCLK;
    input              RST_N;
    output reg  [7:0]  MEM_ADDR;
    output reg         MEM_ADDR_HI;
    output reg         MEM_READ;
    output reg         MEM_WRITE_STROBE;
    output reg  [7:0]  MEM_WDATA;
    output             MEM_WVALID;
    input              MEM_WREADY;
    input       [7:0]  MEM_RDATA;
    output reg  [3:0]  IO_CMD;
    output reg         IO_CMD_VALID;
    input              DMA_IN_REQ;
    input              DMA_OUT_REQ;
    input              INT_REQ;
    input              PROG_LOAD;
    input       [7:0]  DMA_DATA_IN;
    output reg  [7:0]  ACC_OUT;
    output reg         INTERRUPT_GATE;
    output reg  [7:0]  SAVED_CTX;
    output reg  [3:0]  PC_SEL;
    output reg  [3:0]  DP_SEL;
    output reg  [1:0]  CYCLE_STATE;

    // ==========================================================
    // pin synchronisers
    // bit 0 DMA-in, bit 1 DMA-out, bit 2 interrupt, bit 3 program load
    reg  [3:0]  sync1_q;
    reg  [3:0]  sync2_q;
    always @(posedge MCLK) begin
        if (!RST_N) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
        end else begin
            // program load is a pin too, so it is retimed with the requests
            sync1_q <= {PROG_LOAD, INT_REQ, DMA_OUT_REQ, DMA_IN_REQ};
            sync2_q <= sync1_q;
        end
    end

    // program load forces DMA-in only, as the loader feeds bytes
    // masking uses the retimed level so that the mask and the request
    // it gates always come from the same sampling edge
    wire        load_mode = sync2_q[3];
    wire        dma_in    = sync2_q[0];
    wire        dma_out   = sync2_q[1] & ~load_mode;
    wire        int_req   = sync2_q[2] & ~load_mode;

    // ==========================================================
    // register array and sequencing state
    reg  [15:0] regs_q [0:NREG-1];
    reg  [2:0]  pulse_q;
    reg  [3:0]  hi_nib_q;
    reg  [3:0]  lo_nib_q;
    reg  [15:0] abuf_q;
    reg         stall_q;
    reg  [1:0]  wcnt_q;
    // direction of the stolen cycle, fixed when the cycle is granted
    reg         dma_wr_q;

    wire        last_pulse = (pulse_q == `SAS_LAST_PULSE);
    wire        in_exec    = (CYCLE_STATE == `SAS_ST_EXEC);
    wire        in_dma     = (CYCLE_STATE == `SAS_ST_DMA);
    wire        io_out     = (hi_nib_q == `SAS_I_IO) & ~lo_nib_q[3];
    wire        io_in      = (hi_nib_q == `SAS_I_IO) & lo_nib_q[3];
    wire        is_store   = (hi_nib_q == `SAS_I_STORE);
    wire        is_load    = (hi_nib_q == `SAS_I_LOAD);
    wire        alu_mem    = (hi_nib_q == `SAS_I_ALU) & ~lo_nib_q[3];
    wire        alu_imm    = (hi_nib_q == `SAS_I_ALU) & lo_nib_q[3];
    wire        is_step    = (hi_nib_q == `SAS_I_INC) | (hi_nib_q == `SAS_I_DEC);
    wire        is_get     = (hi_nib_q == `SAS_I_GLO) | (hi_nib_q == `SAS_I_GHI);

    // ==========================================================
    // register designator selection
    reg  [3:0]  sel;
    reg         do_mem;
    reg         do_wr;
    reg         do_step;
    reg         step_dn;
    always @* begin
        sel     = PC_SEL;
        do_mem  = 1'b1;
        do_wr   = 1'b0;
        do_step = 1'b1;
        step_dn = 1'b0;
        case (CYCLE_STATE)
            `SAS_ST_FETCH: sel = PC_SEL;
            `SAS_ST_DMA: begin
                sel   = `SAS_R_DMA;
                do_wr = dma_wr_q;
            end
            `SAS_ST_INT: begin
                do_mem  = 1'b0;
                do_step = 1'b0;
            end
            `SAS_ST_EXEC: begin
                if (alu_mem | io_out | io_in) begin
                    sel     = DP_SEL;
                    do_wr   = io_in;
                    do_step = io_out;
                end else if (is_load | is_store) begin
                    sel     = lo_nib_q;
                    do_wr   = is_store;
                    do_step = is_load;
                end else if (alu_imm) begin
                    sel = PC_SEL;
                end else if (is_step | is_get) begin
                    sel     = lo_nib_q;
                    do_mem  = 1'b0;
                    do_step = is_step;
                    step_dn = (hi_nib_q == `SAS_I_DEC);
                end else begin
                    do_mem  = 1'b0;
                    do_step = 1'b0;
                end
            end
            default: sel = PC_SEL;
        endcase
    end

    // ==========================================================
    // two-entry write buffer; a full buffer freezes the sequencer at its write slot
    reg  [7:0]  wb_data_q [0:1];
    reg         wb_wp_q;
    reg         wb_rp_q;
    reg  [1:0]  wb_cnt_q;
    wire        wb_full  = (wb_cnt_q == 2'h2);
    wire        wb_push  = (pulse_q == `SAS_WR_START) & do_wr & ~wb_full & ~stall_q;
    assign      MEM_WVALID = (wb_cnt_q != 2'h0);
    wire        wb_pop   = MEM_WVALID & MEM_WREADY;
    wire [7:0]  wr_data  = in_dma ? DMA_DATA_IN : ACC_OUT;
    wire        hold     = (pulse_q == `SAS_WR_START) & do_wr & wb_full;

    // head pointer after this edge, and whether the incoming word lands on it;
    // an empty buffer, or one emptied by this pop, shows the new word at once
    wire        rp_next  = wb_pop ? ~wb_rp_q : wb_rp_q;
    wire        new_head = wb_push & (wb_wp_q == rp_next);

    always @(posedge MCLK) begin
        if (!RST_N) begin
            wb_wp_q  <= 1'b0;
            wb_rp_q  <= 1'b0;
            wb_cnt_q <= 2'h0;
            MEM_WDATA <= 8'h00;
        end else begin
            if (wb_push) begin
                wb_data_q[wb_wp_q] <= wr_data;
                wb_wp_q <= ~wb_wp_q;
            end
            if (wb_pop)
                wb_rp_q <= ~wb_rp_q;
            wb_cnt_q <= wb_cnt_q + {1'b0, wb_push} - {1'b0, wb_pop};
            // the output always shows the head word, so a stalled receiver
            // sees it steady until it takes it
            if (new_head)
                MEM_WDATA <= wr_data;
            else
                MEM_WDATA <= wb_data_q[rp_next];
        end
    end

    // ==========================================================
    // machine cycle sequencing
    reg  [15:0] stepped;
    always @* begin
        stepped = step_dn ? regs_q[sel] - 16'h0001 : regs_q[sel] + 16'h0001;
    end

    integer k;
    always @(posedge MCLK) begin
        if (!RST_N) begin
            for (k = 0; k < NREG; k = k + 1)
                regs_q[k] <= 16'h0000;
            pulse_q          <= 3'h0;
            CYCLE_STATE      <= `SAS_ST_FETCH;
            PC_SEL           <= `SAS_RST_SEL;
            DP_SEL           <= `SAS_RST_SEL;
            hi_nib_q         <= 4'h0;
            lo_nib_q         <= 4'h0;
            abuf_q           <= 16'h0000;
            ACC_OUT          <= 8'h00;
            INTERRUPT_GATE   <= 1'b1;
            SAVED_CTX        <= 8'h00;
            MEM_ADDR         <= 8'h00;
            MEM_ADDR_HI      <= 1'b0;
            MEM_READ         <= 1'b0;
            MEM_WRITE_STROBE <= 1'b0;
            IO_CMD           <= 4'h0;
            IO_CMD_VALID     <= 1'b0;
            wcnt_q           <= 2'h0;
            stall_q          <= 1'b0;
            dma_wr_q         <= 1'b0;
        end else if (!hold) begin
            pulse_q <= pulse_q + 3'h1;
            // upper byte for one pulse, lower byte after
            if (pulse_q == 3'h0) begin
                abuf_q      <= regs_q[sel];
                MEM_ADDR    <= regs_q[sel][15:8];
                MEM_ADDR_HI <= do_mem;
                MEM_READ    <= do_mem & ~do_wr;
            end else if (pulse_q == `SAS_ADDR_HI_END) begin
                MEM_ADDR    <= abuf_q[7:0];
                MEM_ADDR_HI <= 1'b0;
            end
            // strobe spans pulses five and six, i.e. two MCLK periods
            if (pulse_q == `SAS_WR_START && do_wr) begin
                MEM_WRITE_STROBE <= 1'b1;
                wcnt_q           <= `SAS_WR_LEN;
            end else if (wcnt_q != 2'h0) begin
                wcnt_q <= wcnt_q - 2'h1;
                if (wcnt_q == 2'h1)
                    MEM_WRITE_STROBE <= 1'b0;
            end
            // valid drops on the last pulse so it never spills into the next fetch
            IO_CMD_VALID <= in_exec & (hi_nib_q == `SAS_I_IO) & ~last_pulse;
            if (in_exec & (hi_nib_q == `SAS_I_IO))
                IO_CMD <= lo_nib_q;
            if (pulse_q == `SAS_RD_SAMPLE && CYCLE_STATE == `SAS_ST_FETCH) begin
                hi_nib_q <= MEM_RDATA[7:4];
                lo_nib_q <= MEM_RDATA[3:0];
            end
            if (pulse_q == `SAS_RD_SAMPLE && in_exec && (is_load | alu_mem | alu_imm))
                ACC_OUT <= MEM_RDATA;
            if (last_pulse) begin
                MEM_READ <= 1'b0;
                if (do_step)
                    regs_q[sel] <= stepped;
                if (in_exec && hi_nib_q == `SAS_I_GLO)
                    ACC_OUT <= regs_q[sel][7:0];
                if (in_exec && hi_nib_q == `SAS_I_GHI)
                    ACC_OUT <= regs_q[sel][15:8];
                if (in_exec && hi_nib_q == `SAS_I_SEP)
                    PC_SEL <= lo_nib_q;
                if (in_exec && hi_nib_q == `SAS_I_SEX)
                    DP_SEL <= lo_nib_q;
                // direction is frozen for the whole stolen cycle, since the
                // request pin may drop before the write slot is reached;
                // in wins over out when both are raised together
                if (dma_in | dma_out)
                    dma_wr_q <= dma_in;
                case (CYCLE_STATE)
                    `SAS_ST_FETCH: CYCLE_STATE <= `SAS_ST_EXEC;
                    `SAS_ST_EXEC, `SAS_ST_DMA, `SAS_ST_INT: begin
                        if (dma_in | dma_out)
                            CYCLE_STATE <= `SAS_ST_DMA;
                        else if (int_req & INTERRUPT_GATE & (CYCLE_STATE != `SAS_ST_INT))
                            CYCLE_STATE <= `SAS_ST_INT;
                        else
                            CYCLE_STATE <= `SAS_ST_FETCH;
                    end
                    default: CYCLE_STATE <= `SAS_ST_FETCH;
                endcase
                if (CYCLE_STATE == `SAS_ST_INT) begin
                    SAVED_CTX      <= {DP_SEL, PC_SEL};
                    PC_SEL         <= `SAS_R_INTPC;
                    DP_SEL         <= `SAS_R_INTDP;
                    INTERRUPT_GATE <= 1'b0;
                end
            end
        end
    end
endmodule // sas_top

// [bench/sas_chk.sv]
// pin-level checks on cycle framing, write strobe, address order and buffer
// assumes one clock MCLK and a synchronous active-low reset RST_N
`timescale 1ns/1ns
module sas_chk #(
    parameter NREG = 16
) (
    input logic       MCLK,
    input logic       RST_N,
    input logic       MEM_ADDR_HI,
    input logic       MEM_WRITE_STROBE,
    input logic [7:0] MEM_WDATA,
    input logic       MEM_WVALID,
    input logic       MEM_WREADY,
    input logic       IO_CMD_VALID,
    input logic       PROG_LOAD,
    input logic       INTERRUPT_GATE,
    input logic [3:0] PC_SEL,
    input logic [3:0] DP_SEL,
    input logic [1:0] CYCLE_STATE
);
    // ==========
    // properties
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    sequence s_leave(logic [1:0] st);
        CYCLE_STATE == st ##1 CYCLE_STATE != st;
    endsequence
    sequence s_wr2;
        MEM_WRITE_STROBE [*2] ##1 !MEM_WRITE_STROBE;
    endsequence
    strobe_width_a: assert property ($rose(MEM_WRITE_STROBE) |-> s_wr2)
        else $error("strobe width");
    addr_order_a: assert property ($rose(MEM_ADDR_HI) |=> !MEM_ADDR_HI)
        else $error("upper byte held");
    fetch_exec_a: assert property (s_leave(2'h0) |-> CYCLE_STATE == 2'h1)
        else $error("fetch not followed by execute");
    cycle_len_a: assert property ($changed(CYCLE_STATE) |=> $stable(CYCLE_STATE) [*7])
        else $error("cycle shorter than eight");
    int_gate_a: assert property ($rose(CYCLE_STATE == 2'h3) |->
        $past(INTERRUPT_GATE) && !$past(PROG_LOAD)) else $error("interrupt not refused");
    int_ctx_a: assert property (s_leave(2'h3) |-> PC_SEL == 4'h1 && DP_SEL == 4'h2
        && !INTERRUPT_GATE) else $error("interrupt context");
    wbuf_hold_a: assert property (MEM_WVALID && !MEM_WREADY |=>
        MEM_WVALID && $stable(MEM_WDATA)) else $error("buffered word lost");
    io_exec_a: assert property (IO_CMD_VALID |-> CYCLE_STATE == 2'h1)
        else $error("command outside execute");
endmodule // sas_chk

bind sas_top sas_chk #(.NREG(NREG)) chk_u (.MCLK(MCLK), .RST_N(RST_N),
    .MEM_ADDR_HI(MEM_ADDR_HI), .MEM_WRITE_STROBE(MEM_WRITE_STROBE), .MEM_WDATA(MEM_WDATA),
    .MEM_WVALID(MEM_WVALID), .MEM_WREADY(MEM_WREADY), .IO_CMD_VALID(IO_CMD_VALID),
    .PROG_LOAD(PROG_LOAD), .INTERRUPT_GATE(INTERRUPT_GATE), .PC_SEL(PC_SEL),
    .DP_SEL(DP_SEL), .CYCLE_STATE(CYCLE_STATE));

// [bench/sas_mem.sv]
// memory partner: byte array behind the multiplexed address and write buffer
// assumes the upper address byte is flagged by addr_hi before the lower one
`timescale 1ns/1ns
module sas_mem (
    input  logic        clk,
    input  logic [7:0]  addr,
    input  logic        addr_hi,
    input  logic        rd,
    input  logic        strobe,
    input  logic [7:0]  wdata,
    input  logic        wvalid,
    input  logic        stall,
    output logic        wready,
    output logic [7:0]  rdata,
    output logic        wr_fire,
    output logic [23:0] wr_ent
);
    // ==============
    // storage and bus
    logic [7:0]  mem [0:65535];
    logic [7:0]  hi_q = 8'h00;
    logic [7:0]  last_q = 8'h00;
    logic        st_q = 1'b0;
    logic [15:0] aq [$];
    initial {wready, wr_fire, wr_ent} = '0;
    // a released bus reads back inverted so a stale byte never looks fresh
    assign rdata = rd ? mem[{hi_q, addr}] : ~last_q;
    always @(posedge clk) begin
        if (addr_hi) hi_q <= addr;
        if (rd) last_q <= rdata;
        st_q <= strobe;
        if (strobe && !st_q) aq.push_back({hi_q, addr});
        wr_fire <= wvalid && wready;
        if (wvalid && wready) begin
            mem[aq[0]] <= wdata;
            wr_ent <= {aq.pop_front(), wdata};
        end
        // random back-pressure unless the bench holds the write side off
        wready <= !stall && ($urandom % 3 != 0);
    end
endmodule // sas_mem

// [bench/tb.sv]
// self-checking bench: program run, stall, DMA and interrupt on the sequencer
// assumes sas_top, the memory partner and the bound checker are compiled first
`timescale 1ns/1ns
module tb;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        dma_in = 1'b0;
    logic        dma_out = 1'b0;
    logic        int_req = 1'b0;
    logic        prog_load = 1'b0;
    logic        stall = 1'b0;
    logic        io_q = 1'b0;
    logic [7:0]  dma_data = 8'h00;
    logic [7:0]  addr, wdata, rdata, acc, ctx;
    logic [3:0]  io_cmd, pc_sel, dp_sel;
    logic [1:0]  cst;
    logic        addr_hi, rd, strobe, wvalid, wready, io_v, gate, wr_fire;
    logic [23:0] wr_ent;
    logic [23:0] wq [$];
    logic [23:0] ioq [$];
    int          fails = 0;
    int          n_compared = 0;
    always #5 mclk = ~mclk;
    sas_top #(.NREG(16)) dut_u (.MCLK(mclk), .RST_N(rst_n), .MEM_ADDR(addr),
        .MEM_ADDR_HI(addr_hi), .MEM_READ(rd), .MEM_WRITE_STROBE(strobe), .MEM_WDATA(wdata),
        .MEM_WVALID(wvalid), .MEM_WREADY(wready), .MEM_RDATA(rdata), .IO_CMD(io_cmd),
        .IO_CMD_VALID(io_v), .DMA_IN_REQ(dma_in), .DMA_OUT_REQ(dma_out), .INT_REQ(int_req),
        .PROG_LOAD(prog_load), .DMA_DATA_IN(dma_data), .ACC_OUT(acc), .INTERRUPT_GATE(gate),
        .SAVED_CTX(ctx), .PC_SEL(pc_sel), .DP_SEL(dp_sel), .CYCLE_STATE(cst));
    sas_mem mem_u (.clk(mclk), .addr(addr), .addr_hi(addr_hi), .rd(rd), .strobe(strobe),
        .wdata(wdata), .wvalid(wvalid), .stall(stall), .wready(wready), .rdata(rdata),
        .wr_fire(wr_fire), .wr_ent(wr_ent));
    // ==================
    // checking and tasks
    task automatic cmp(input string nm, input logic [23:0] e, input logic [23:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge mclk) begin
        io_q <= io_v;
        if (wr_fire) cmp("write", wq.size() ? wq.pop_front() : 'x, wr_ent);
        if (io_v && !io_q) cmp("iocmd", ioq.size() ? ioq.pop_front() : 'x, 24'(io_cmd));
    end
    task automatic wait_st(input logic [1:0] s, input logic [1:0] bad);
        int k;
        k = 0;
        do begin
            @(posedge mclk);
            #1;
            k++;
            if (cst === bad && bad !== s) cmp("order", 24'(s), 24'(cst));
        end while (cst !== s && k < 400);
        if (k >= 400) cmp("state", 24'(s), 24'(cst));
    endtask
    task automatic wait_q;
        int k;
        for (k = 0; k < 3000 && (wq.size() || ioq.size()); k++) @(posedge mclk);
        if (k == 3000) cmp("drain", 24'h0, 24'(wq.size() + ioq.size()));
    endtask
    // one stolen cycle, or two back to back; nx is the state that must follow
    task automatic dma(input bit o, input int n, input logic [15:0] a, input logic [1:0] nx);
        logic [7:0] v;
        v = $urandom;
        @(posedge mclk);
        dma_data <= v;
        int_req <= (nx == 2'h3);
        for (int i = 0; i < n; i++) if (!o) wq.push_back({a + 16'(i), v});
        if (o) dma_out <= 1'b1;
        else dma_in <= 1'b1;
        wait_st(2'h2, 2'h3);
        if (n > 1) begin
            repeat (8) @(posedge mclk);
            #1 cmp("burst", 24'(cst), 24'h2);
        end
        @(posedge mclk);
        dma_in <= 1'b0;
        dma_out <= 1'b0;
        wait_st(nx, nx);
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        $display("[ERR] watchdog expired");
        final_report();
    end
    initial begin
        logic [7:0] a, b;
        logic [7:0] pg [17];
        void'($urandom(36688));
        a = $urandom;
        b = $urandom;
        // three incs of R1 then a switch to it, so R0 stays free for stolen cycles
        pg = '{8'h11, 8'h11, 8'h11, 8'hE4, 8'hD1, 8'hE5, 8'h25, 8'hF0, 8'h56,
               8'h16, 8'h85, 8'h56, 8'hF8, b, 8'h56, 8'h56, 8'h56};
        for (int i = 0; i < 65536; i++) mem_u.mem[i] = 8'hE5;
        for (int i = 0; i < 17; i++) mem_u.mem[i] = pg[i];
        for (int i = 0; i < 8; i++) begin
            mem_u.mem[17 + i] = 8'h60 + 8'(i);
            ioq.push_back(24'(i));
        end
        mem_u.mem[16'hFFFF] = a;
        wq = '{{16'h0, a}, {16'h1, 8'hFF}, {16'h1, b}, {16'h1, b}, {16'h1, b}};
        repeat (16) @(posedge mclk);
        cmp("reset", {pc_sel, dp_sel, ctx, gate, cst}, {16'h0, 1'b1, 2'h0});
        rst_n <= 1'b1;
        repeat (190) @(posedge mclk);
        stall <= 1'b1;
        repeat (150) @(posedge mclk);
        stall <= 1'b0;
        wait_q();
        cmp("dsel", 24'(dp_sel), 24'h5);
        $display("test program done");
        dma(1'b0, 1, 16'h0005, 2'h3);
        wait_st(2'h0, 2'h0);
        cmp("int", {pc_sel, dp_sel, ctx, gate}, {4'h1, 4'h2, 8'h51, 1'b0});
        $display("test dma irq done");
        @(posedge mclk);
        prog_load <= 1'b1;
        dma(1'b0, 2, 16'h0006, 2'h0);
        @(posedge mclk);
        prog_load <= 1'b0;
        dma(1'b1, 1, 16'h0008, 2'h0);
        dma(1'b0, 1, 16'h0009, 2'h0);
        wait_q();
        $display("test dma done");
        final_report();
    end
endmodule // tb
